// File: core/i2c_gc_pkg.sv
// Purpose: Shared constants for the two-wire slave with stretch and general-call control.
// Assumes: Wishbone registers at word-aligned byte offsets, 8 data bits per register.
// Notes:   Status and interrupt layouts are shared by the core and its assertions.
package i2c_gc_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [5:0] OFS_CTRL   = 6'h00;
	localparam logic [5:0] OFS_OWNADR = 6'h04;
	localparam logic [5:0] OFS_ALT    = 6'h08;
	localparam logic [5:0] OFS_STATUS = 6'h0c;
	localparam logic [5:0] OFS_RXDATA = 6'h10;
	localparam logic [5:0] OFS_TXDATA = 6'h14;
	localparam logic [5:0] OFS_IRQSTA = 6'h18;
	localparam logic [5:0] OFS_IRQCLR = 6'h1c;
	localparam logic [5:0] OFS_IRQEN  = 6'h20;

	// ------------------------------------------------------------
	// Control bit positions
	// ------------------------------------------------------------
	localparam int CTL_SLAVE_EN = 0;
	localparam int CTL_GC_EN    = 2;
	localparam int CTL_HGC_EN   = 3;
	localparam int CTL_GC_CLR   = 4;
	localparam int CTL_EARLY_TX = 5;
	localparam int CTL_STRETCH  = 6;

	// ------------------------------------------------------------
	// Status and interrupt layout
	// ------------------------------------------------------------
	localparam int STA_GC_FLAG = 0;
	localparam int STA_GC_ID   = 1;
	localparam int STA_BUSY    = 3;
	localparam int IRQ_TX_REQ  = 0;
	localparam int IRQ_RX_BYTE = 1;
	localparam int IRQ_STOP    = 2;
	localparam int IRQ_GC      = 3;
	localparam int IRQ_HW_GC   = 4;
	localparam int IRQ_W       = 5;

	// ------------------------------------------------------------
	// Codes, counts and reset values
	// ------------------------------------------------------------
	localparam logic [1:0] GCID_NONE  = 2'h0;
	localparam logic [1:0] GCID_RESET = 2'h1;
	localparam logic [1:0] GCID_PROG  = 2'h2;
	localparam logic [1:0] GCID_HW    = 2'h3;
	localparam logic [7:0] GC_ADDR    = 8'h00;
	localparam logic [7:0] GC_BYTE_RESET = 8'h06;
	localparam logic [7:0] GC_BYTE_PROG  = 8'h04;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [7:0] CTRL_RST   = 8'h00;
	localparam logic [6:0] OWNADR_RST = 7'h00;
	localparam logic [7:0] ALT_RST    = 8'h00;

endpackage : i2c_gc_pkg

// File: core/sync2.sv
// Purpose: Two-flop synchroniser for a level from outside the clock domain.
// Assumes: Input changes slowly against clk_sys.
// Notes:   Only the second flop is visible outside.
`timescale 1ns/1ps
module sync2 #(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic d,
	output logic      q
);
	logic meta_q;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RST_VAL;
			q      <= RST_VAL;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : sync2

// File: core/byte_shift.sv
// Purpose: Eight-bit shift register, loaded in parallel and shifted MSB first.
// Assumes: load and shift are never high together; load wins if they are.
// Notes:   Serves both receive and transmit because the link is half duplex.
`timescale 1ns/1ps
module byte_shift (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       load,
	input  wire logic [7:0] load_val,
	input  wire logic       shift,
	input  wire logic       bit_in,
	output logic [7:0]      val_q
);
	logic [7:0] val_d;

	always_comb begin
		val_d = val_q;
		if (load) begin
			val_d = load_val;
		end else if (shift) begin
			val_d = {val_q[6:0], bit_in};
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			val_q <= 8'h00;
		end else begin
			val_q <= val_d;
		end
	end
endmodule : byte_shift

// File: core/i2c_slave_gc_ctrl.sv
// Purpose: Two-wire slave with forced clock stretching and general-call handling.
// Assumes: clk_sys well above eight times the serial clock rate; pins are open drain.
// Notes:   Wishbone classic slave, one wait state, 8-bit registers in the low byte.
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module i2c_slave_gc_ctrl (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [5:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	output logic             irq_o
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0, ST_ADDR = 3'h1, ST_ADDR_ACK = 3'h3, ST_RX = 3'h2,
		ST_RX_ACK = 3'h6, ST_TX = 3'h7, ST_TX_ACK = 3'h5
	} state_t;

	// ------------------------------------------------------------
	// Pin sampling
	// ------------------------------------------------------------
	logic scl_s, sda_s, scl_p_q, sda_p_q;
	logic scl_rise, scl_fall, start_det, stop_det;

	sync2 #(.RST_VAL(1'b1)) u_scl_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.d       (scl_i),
		.q       (scl_s)
	);
	sync2 #(.RST_VAL(1'b1)) u_sda_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.d       (sda_i),
		.q       (sda_s)
	);

	assign scl_rise  = scl_s & ~scl_p_q;
	assign scl_fall  = ~scl_s & scl_p_q;
	assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;

	// ------------------------------------------------------------
	// Register and serial state
	// ------------------------------------------------------------
	logic [7:0]  ctrl_q, ctrl_d, alt_q, alt_d, rxd_q, rxd_d, txd_q, txd_d;
	logic [6:0]  own_q, own_d;
	logic        gc_flag_q, gc_flag_d;
	logic [1:0]  gc_id_q, gc_id_d;
	logic [4:0]  ista_q, ista_d, ien_q, ien_d;
	logic        ack_q, ack_d, hold_q, hold_d;
	logic [31:0] rdat_q, rdat_d;
	state_t      st_q, st_d;
	logic [3:0]  cnt_q, cnt_d;
	logic        drv_q, drv_d, rw_q, rw_d, gcm_q, gcm_d;
	logic        sh_load, sh_shift;
	logic [7:0]  sh_q;
	logic        tx_ev, rx_ev, gc_ev, hgc_ev, gc_clr, addr_rd_hit;
	logic        hgc_on, wr_stb;
	logic [1:0]  gc_id_new;

	assign hgc_on = ctrl_q[i2c_gc_pkg::CTL_HGC_EN] & ctrl_q[i2c_gc_pkg::CTL_GC_EN];
	assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q & wb_sel_i[0];
	assign gc_clr = wr_stb & (wb_adr_i == i2c_gc_pkg::OFS_CTRL)
		& wb_dat_i[i2c_gc_pkg::CTL_GC_CLR];
	assign addr_rd_hit = (st_q == ST_ADDR) && (cnt_q == 4'h7) && sda_s
		&& (sh_q[6:0] == own_q) && ctrl_q[i2c_gc_pkg::CTL_SLAVE_EN];

	byte_shift u_shift (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.load     (sh_load),
		.load_val (txd_q),
		.shift    (sh_shift),
		.bit_in   (sda_s),
		.val_q    (sh_q)
	);

	// ------------------------------------------------------------
	// Serial state machine
	// ------------------------------------------------------------
	// SDA only changes on a falling clock edge so a held line never glitches the data phase.
	always_comb begin
		st_d      = st_q;
		cnt_d     = cnt_q;
		drv_d     = drv_q;
		rw_d      = rw_q;
		gcm_d     = gcm_q;
		rxd_d     = rxd_q;
		sh_load   = 1'b0;
		sh_shift  = 1'b0;
		tx_ev     = 1'b0;
		rx_ev     = 1'b0;
		gc_ev     = 1'b0;
		hgc_ev    = 1'b0;
		gc_id_new = i2c_gc_pkg::GCID_NONE;
		if (stop_det) begin
			st_d  = ST_IDLE;
			drv_d = 1'b0;
		end else if (start_det) begin
			st_d  = ST_ADDR;
			cnt_d = 4'h0;
			drv_d = 1'b0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					drv_d = 1'b0;
				end
				ST_ADDR, ST_RX: begin
					if (scl_rise && cnt_q != i2c_gc_pkg::BITS_PER_BYTE) begin
						sh_shift = 1'b1;
						cnt_d    = cnt_q + 4'h1;
						if (addr_rd_hit && ctrl_q[i2c_gc_pkg::CTL_EARLY_TX]) begin
							tx_ev = 1'b1;
						end
					end else if (scl_fall && cnt_q == i2c_gc_pkg::BITS_PER_BYTE) begin
						if (st_q == ST_ADDR) begin
							rw_d  = sh_q[0];
							gcm_d = 1'b0;
							if (!ctrl_q[i2c_gc_pkg::CTL_SLAVE_EN]) begin
								st_d = ST_IDLE;
							end else if (sh_q[7:1] == own_q) begin
								st_d  = ST_ADDR_ACK;
								drv_d = 1'b1;
								if (sh_q[0] && !ctrl_q[i2c_gc_pkg::CTL_EARLY_TX]) begin
									tx_ev = 1'b1;
								end
							end else if (sh_q == i2c_gc_pkg::GC_ADDR
								&& ctrl_q[i2c_gc_pkg::CTL_GC_EN]) begin
								st_d  = ST_ADDR_ACK;
								drv_d = 1'b1;
								gcm_d = 1'b1;
							end else begin
								st_d = ST_IDLE;
							end
						end else begin
							st_d  = ST_RX_ACK;
							drv_d = 1'b1;
							rxd_d = sh_q;
							rx_ev = 1'b1;
							gcm_d = 1'b0;
							if (gcm_q) begin
								gc_ev = 1'b1;
								if (hgc_on && sh_q == alt_q) begin
									hgc_ev    = 1'b1;
									gc_id_new = i2c_gc_pkg::GCID_HW;
								end else if (sh_q == i2c_gc_pkg::GC_BYTE_RESET) begin
									gc_id_new = i2c_gc_pkg::GCID_RESET;
								end else if (sh_q == i2c_gc_pkg::GC_BYTE_PROG) begin
									gc_id_new = i2c_gc_pkg::GCID_PROG;
								end
							end
						end
					end
				end
				ST_ADDR_ACK, ST_RX_ACK: begin
					if (scl_fall) begin
						cnt_d = 4'h0;
						drv_d = 1'b0;
						if (st_q == ST_ADDR_ACK && rw_q) begin
							st_d    = ST_TX;
							sh_load = 1'b1;
							cnt_d   = 4'h1;
							drv_d   = ~txd_q[7];
						end else begin
							st_d = ST_RX;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (cnt_q == i2c_gc_pkg::BITS_PER_BYTE) begin
							st_d  = ST_TX_ACK;
							drv_d = 1'b0;
						end else begin
							sh_shift = 1'b1;
							cnt_d    = cnt_q + 4'h1;
							drv_d    = ~sh_q[6];
						end
					end
				end
				ST_TX_ACK: begin
					if (scl_rise) begin
						if (sda_s) begin
							st_d = ST_IDLE;
						end else begin
							tx_ev = 1'b1;
						end
					end else if (scl_fall) begin
						st_d    = ST_TX;
						sh_load = 1'b1;
						cnt_d   = 4'h1;
						drv_d   = ~txd_q[7];
					end
				end
				default: begin
					st_d  = ST_IDLE;
					drv_d = 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Register file and clock stretch
	// ------------------------------------------------------------
	// The clear bit is an action, not stored; a general call arriving with the clear wins.
	always_comb begin
		ctrl_d    = ctrl_q;
		own_d     = own_q;
		alt_d     = alt_q;
		txd_d     = txd_q;
		ien_d     = ien_q;
		ista_d    = ista_q | {hgc_ev, gc_ev, stop_det & (st_q != ST_IDLE), rx_ev, tx_ev};
		gc_flag_d = gc_flag_q;
		gc_id_d   = gc_id_q;
		ack_d     = wb_cyc_i & wb_stb_i & ~ack_q;
		rdat_d    = 32'h0000_0000;
		if (gc_clr) begin
			gc_flag_d = 1'b0;
			gc_id_d   = i2c_gc_pkg::GCID_NONE;
		end
		if (gc_ev) begin
			gc_flag_d = 1'b1;
			gc_id_d   = gc_id_new;
		end
		if (wr_stb) begin
			case (wb_adr_i)
				i2c_gc_pkg::OFS_CTRL: begin
					ctrl_d = wb_dat_i[7:0] & ~(8'h01 << i2c_gc_pkg::CTL_GC_CLR);
				end
				i2c_gc_pkg::OFS_OWNADR: own_d = wb_dat_i[6:0];
				i2c_gc_pkg::OFS_ALT:    alt_d = wb_dat_i[7:0];
				i2c_gc_pkg::OFS_TXDATA: txd_d = wb_dat_i[7:0];
				i2c_gc_pkg::OFS_IRQCLR: begin
					ista_d = (ista_q & ~wb_dat_i[4:0])
						| {hgc_ev, gc_ev, stop_det & (st_q != ST_IDLE), rx_ev, tx_ev};
				end
				i2c_gc_pkg::OFS_IRQEN:  ien_d = wb_dat_i[4:0];
				default: begin
				end
			endcase
		end
		case (wb_adr_i)
			i2c_gc_pkg::OFS_CTRL:   rdat_d[7:0] = ctrl_q;
			i2c_gc_pkg::OFS_OWNADR: rdat_d[6:0] = own_q;
			i2c_gc_pkg::OFS_ALT:    rdat_d[7:0] = alt_q;
			i2c_gc_pkg::OFS_STATUS: rdat_d[3:0] = {st_q != ST_IDLE, gc_id_q, gc_flag_q};
			i2c_gc_pkg::OFS_RXDATA: rdat_d[7:0] = rxd_q;
			i2c_gc_pkg::OFS_TXDATA: rdat_d[7:0] = txd_q;
			i2c_gc_pkg::OFS_IRQSTA: rdat_d[4:0] = ista_q;
			i2c_gc_pkg::OFS_IRQEN:  rdat_d[4:0] = ien_q;
			default:                rdat_d      = 32'h0000_0000;
		endcase
		// A high line only gets held once it falls, so the master's high phase is never cut.
		hold_d = ctrl_q[i2c_gc_pkg::CTL_STRETCH] & (hold_q | ~scl_s);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q    <= i2c_gc_pkg::CTRL_RST;
			own_q     <= i2c_gc_pkg::OWNADR_RST;
			alt_q     <= i2c_gc_pkg::ALT_RST;
			txd_q     <= 8'h00;
			rxd_q     <= 8'h00;
			ien_q     <= 5'h00;
			ista_q    <= 5'h00;
			gc_flag_q <= 1'b0;
			gc_id_q   <= i2c_gc_pkg::GCID_NONE;
			ack_q     <= 1'b0;
			rdat_q    <= 32'h0000_0000;
			hold_q    <= 1'b0;
			st_q      <= ST_IDLE;
			cnt_q     <= 4'h0;
			drv_q     <= 1'b0;
			rw_q      <= 1'b0;
			gcm_q     <= 1'b0;
			scl_p_q   <= 1'b1;
			sda_p_q   <= 1'b1;
		end else begin
			ctrl_q    <= ctrl_d;
			own_q     <= own_d;
			alt_q     <= alt_d;
			txd_q     <= txd_d;
			rxd_q     <= rxd_d;
			ien_q     <= ien_d;
			ista_q    <= ista_d;
			gc_flag_q <= gc_flag_d;
			gc_id_q   <= gc_id_d;
			ack_q     <= ack_d;
			rdat_q    <= rdat_d;
			hold_q    <= hold_d;
			st_q      <= st_d;
			cnt_q     <= cnt_d;
			drv_q     <= drv_d;
			rw_q      <= rw_d;
			gcm_q     <= gcm_d;
			scl_p_q   <= scl_s;
			sda_p_q   <= sda_s;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign scl_o    = 1'b0;
	assign scl_oe   = hold_q;
	assign sda_o    = 1'b0;
	assign sda_oe   = drv_q;
	assign irq_o    = |(ista_q & ien_q);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_stretch_low_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ctrl_q[i2c_gc_pkg::CTL_STRETCH] && !scl_s ##1 ctrl_q[i2c_gc_pkg::CTL_STRETCH]
		|-> scl_oe) else $error("clock not held while low with stretch set");
	a_stretch_fall_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		scl_fall && ctrl_q[i2c_gc_pkg::CTL_STRETCH] && ctrl_d[i2c_gc_pkg::CTL_STRETCH]
		|=> scl_oe) else $error("clock not held after fall");
	// The hold register lags the control bit by one cycle, so release is checked a cycle on.
	a_stretch_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!ctrl_q[i2c_gc_pkg::CTL_STRETCH] |=> !scl_oe)
		else $error("clock held with stretch clear");
	a_early_tx_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
		tx_ev && st_q == ST_ADDR && ctrl_q[i2c_gc_pkg::CTL_EARLY_TX] |-> scl_rise
		##1 ista_q[i2c_gc_pkg::IRQ_TX_REQ]) else $error("early request off edge");
	a_late_tx_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
		tx_ev && st_q == ST_ADDR && !ctrl_q[i2c_gc_pkg::CTL_EARLY_TX] |-> scl_fall
		##1 (st_q == ST_ADDR_ACK && rw_q)) else $error("late request off edge");
	a_gc_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
		gc_clr && !gc_ev |=> !gc_flag_q && gc_id_q == i2c_gc_pkg::GCID_NONE)
		else $error("general call status not cleared");
	a_hw_gc_match: assert property (@(posedge clk_sys) disable iff (!rst_n)
		hgc_ev |-> gcm_q && sh_q == alt_q ##1 gc_id_q == i2c_gc_pkg::GCID_HW)
		else $error("hardware general call without match");
	a_hw_gc_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
		hgc_ev |-> ctrl_q[i2c_gc_pkg::CTL_HGC_EN] && ctrl_q[i2c_gc_pkg::CTL_GC_EN])
		else $error("hardware general call while disabled");
	a_gc_ack_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(st_q == ST_ADDR_ACK) && gcm_q |-> sda_oe && ctrl_q[i2c_gc_pkg::CTL_GC_EN])
		else $error("general call acknowledged while disabled");
	a_plain_gc: assert property (@(posedge clk_sys) disable iff (!rst_n)
		gc_ev && sh_q != alt_q |-> !hgc_ev ##1 gc_flag_q)
		else $error("plain general call flagged as hardware");
endmodule : i2c_slave_gc_ctrl

// File: dv/i2c_master_model.sv
// Purpose: Behavioural two-wire bus master that pulls the open-drain lines.
// Assumes: A pull output is high while this side holds its line low.
// Notes:   The half period is an input so one test can run the link slowly.
`timescale 1ns/1ps
module i2c_master_model (
	input  wire logic       clk_sys,
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic [4:0] half,
	output logic            scl_pull,
	output logic            sda_pull,
	output logic            stuck
);
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
		stuck    = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick
	// The slave may stretch, so the high phase counts only once it is seen.
	task automatic rise();
		int n;
		scl_pull <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (scl !== 1'b1 && n < 800);
		if (n >= 800) stuck <= 1'b1;
		tick(int'(half) - 1);
	endtask : rise
	task automatic fall();
		scl_pull <= 1'b1;
		tick(1);
	endtask : fall
	task automatic bit_io(input logic b, output logic s);
		sda_pull <= ~b;
		tick(int'(half) - 1);
		rise();
		s = sda;
		fall();
	endtask : bit_io
	task automatic start();
		sda_pull <= 1'b1;
		tick(int'(half));
		fall();
	endtask : start
	task automatic stop();
		sda_pull <= 1'b1;
		tick(int'(half) - 1);
		rise();
		sda_pull <= 1'b0;
		tick(int'(half));
	endtask : stop
	task automatic let_go();
		scl_pull <= 1'b0;
	endtask : let_go
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = (s === 1'b0);
	endtask : wr_byte
	task automatic rd_byte(output logic [7:0] d, input logic nack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(nack, s);
	endtask : rd_byte
endmodule : i2c_master_model

// File: dv/tb_top.sv
// Purpose: Self-checking bench for stretch, early transmit and general-call control.
// Assumes: Both bus lines have pull-ups; the wire level is the AND of all parties.
// Notes:   Status and interrupt reads are masked to the bits under test.
`timescale 1ns/1ps
module tb_top;
	logic        clk_sys;
	logic        rst_n;
	logic        wb_cyc, wb_stb, wb_we, wb_ack, scl_o, scl_oe, sda_o, sda_oe, irq;
	logic [5:0]  wb_adr;
	logic [31:0] wb_dat, wb_rdat;
	logic [3:0]  wb_sel;
	logic        scl_pull, sda_pull, stuck, scl, sda, irq_d, scl_d, irq_scl;
	logic [4:0]  half;
	int          errors = 0, comparisons = 0, rises = 0, irq_rises = 0;
	assign scl = ~(scl_pull | scl_oe);
	assign sda = ~(sda_pull | sda_oe);
	i2c_slave_gc_ctrl i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
		.wb_sel_i(wb_sel), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .scl_i(scl),
		.scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
		.irq_o(irq));
	i2c_master_model i_mst (.clk_sys(clk_sys), .scl(scl), .sda(sda), .half(half),
		.scl_pull(scl_pull), .sda_pull(sda_pull), .stuck(stuck));
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// Records where on the link clock the interrupt line last went high.
	always @(posedge clk_sys) begin
		irq_d <= irq;
		scl_d <= scl;
		if (scl === 1'b1 && scl_d === 1'b0) rises <= rises + 1;
		if (irq === 1'b1 && irq_d === 1'b0) begin
			irq_scl   <= scl;
			irq_rises <= rises;
		end
	end
	task automatic tally_and_finish();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic wb_io(input logic [5:0] a, input logic w, input logic [7:0] d,
		output logic [7:0] r);
		int n;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= w;
		wb_adr <= a;
		wb_dat <= {24'h000000, d};
		wb_sel <= 4'hf;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			errors++;
			$display("BAD %0t no bus ack", $time);
			tally_and_finish();
		end
		r = wb_rdat[7:0];
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_sys);
	endtask : wb_io
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] r;
		wb_io(a, 1'b1, d, r);
	endtask : wr
	task automatic rd_chk(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m);
		logic [7:0] r;
		wb_io(a, 1'b0, 8'h00, r);
		chk(r & m, e & m, "register read");
	endtask : rd_chk
	task automatic gc_case(input logic [7:0] c, input logic [7:0] b, input logic ea,
		input logic [7:0] es, input logic [7:0] ei);
		logic a;
		wr(i2c_gc_pkg::OFS_CTRL, c);
		i_mst.start();
		i_mst.wr_byte(i2c_gc_pkg::GC_ADDR, a);
		chk({7'h00, a}, {7'h00, ea}, "general call address ack");
		if (a) i_mst.wr_byte(b, a);
		i_mst.stop();
		rd_chk(i2c_gc_pkg::OFS_STATUS, es, 8'h07);
		if (ea) rd_chk(i2c_gc_pkg::OFS_RXDATA, b, 8'hff);
		rd_chk(i2c_gc_pkg::OFS_IRQSTA, ei, 8'h18);
		chk({7'h00, irq}, {7'h00, |(ei & 8'h10)}, "irq level");
		wr(i2c_gc_pkg::OFS_CTRL, c | 8'h10);
		rd_chk(i2c_gc_pkg::OFS_STATUS, 8'h00, 8'h07);
		rd_chk(i2c_gc_pkg::OFS_CTRL, c, 8'hff);
		wr(i2c_gc_pkg::OFS_IRQCLR, 8'h1f);
		chk({7'h00, irq}, 8'h00, "irq after clear");
		$display("test general call done");
	endtask : gc_case
	task automatic stretch_case(input logic idle_first);
		if (idle_first) begin
			wr(i2c_gc_pkg::OFS_CTRL, 8'h41);
			i_mst.tick(8);
			chk({7'h00, scl_oe}, 8'h00, "no hold while clock high");
		end
		i_mst.start();
		if (!idle_first) wr(i2c_gc_pkg::OFS_CTRL, 8'h41);
		i_mst.tick(6);
		i_mst.let_go();
		i_mst.tick(20);
		chk({7'h00, scl}, 8'h00, "clock held low");
		wr(i2c_gc_pkg::OFS_CTRL, 8'h01);
		i_mst.tick(2);
		chk({7'h00, scl}, 8'h01, "clock let go");
		i_mst.stop();
		$display("test stretch done");
	endtask : stretch_case
	task automatic tx_case(input logic early);
		logic a;
		logic [7:0] d;
		int base;
		half <= 5'h10;
		wr(i2c_gc_pkg::OFS_TXDATA, 8'ha5);
		wr(i2c_gc_pkg::OFS_CTRL, {2'h0, early, 5'h01});
		wr(i2c_gc_pkg::OFS_IRQEN, 8'h01);
		base = rises;
		i_mst.start();
		i_mst.wr_byte(8'h55, a);
		i_mst.rd_byte(d, 1'b1);
		i_mst.stop();
		chk({7'h00, irq_scl}, {7'h00, early}, "request edge");
		chk(8'(irq_rises - base), 8'h08, "request bit");
		chk(d, 8'ha5, "read data");
		chk({6'h00, scl_o, sda_o}, 8'h00, "open drain levels");
		wr(i2c_gc_pkg::OFS_IRQCLR, 8'h1f);
		wr(i2c_gc_pkg::OFS_IRQEN, 8'h10);
		half <= 5'h04;
		$display("test early transmit done");
	endtask : tx_case
	initial begin
		repeat (100000) @(posedge clk_sys);
		errors++;
		$display("BAD %0t run too long", $time);
		tally_and_finish();
	end
	initial begin
		rst_n  = 1'b0;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we  = 1'b0;
		wb_adr = 6'h00;
		wb_dat = 32'h00000000;
		wb_sel = 4'h0;
		half   = 5'h04;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rd_chk(i2c_gc_pkg::OFS_CTRL, i2c_gc_pkg::CTRL_RST, 8'hff);
		rd_chk(i2c_gc_pkg::OFS_ALT, i2c_gc_pkg::ALT_RST, 8'hff);
		rd_chk(i2c_gc_pkg::OFS_STATUS, 8'h00, 8'hff);
		wr(6'h3c, 8'hff);
		rd_chk(6'h3c, 8'h00, 8'hff);
		wr(i2c_gc_pkg::OFS_OWNADR, 8'h2a);
		wr(i2c_gc_pkg::OFS_ALT, 8'h55);
		wr(i2c_gc_pkg::OFS_IRQEN, 8'h10);
		rd_chk(i2c_gc_pkg::OFS_IRQEN, 8'h10, 8'hff);
		$display("test registers done");
		gc_case(8'h0d, 8'h55, 1'b1, 8'h07, 8'h18);
		gc_case(8'h05, 8'h55, 1'b1, 8'h01, 8'h08);
		gc_case(8'h0d, 8'h33, 1'b1, 8'h01, 8'h08);
		gc_case(8'h0d, 8'h06, 1'b1, 8'h03, 8'h08);
		gc_case(8'h05, 8'h04, 1'b1, 8'h05, 8'h08);
		gc_case(8'h09, 8'h55, 1'b0, 8'h00, 8'h00);
		stretch_case(1'b1);
		stretch_case(1'b0);
		tx_case(1'b1);
		tx_case(1'b0);
		chk({7'h00, stuck}, 8'h00, "link clock stuck");
		tally_and_finish();
	end
endmodule : tb_top
